// file: inc/ufc_pkg.sv
// How it works
// - control bit 0 enables both FIFOs
// - control bit 2 clears transmit FIFO, self-clears
// - control bit 1 clears receive FIFO, self-clears
// - bits 7:6 pick receive level 8/16/24/28
// - receive ready at level, also flow stop
// - bits 5:4 pick transmit level 16/8/24/30
// - transmit empty event when count falls below level
// - any non-zero level register overrides coded levels
// - receive ready withdrawn when count below level
// - status read or data write clears transmit event
package ufc_pkg;
  // fifo geometry
  localparam int unsigned DEPTH = 32;
  localparam int unsigned AW    = 5;
  localparam int unsigned CW    = 6;
  localparam int unsigned DW    = 8;
  localparam int unsigned ADW   = 4;

  typedef logic [DW-1:0]  ufc_byte_t;
  typedef logic [CW-1:0]  ufc_cnt_t;
  typedef logic [ADW-1:0] ufc_addr_t;

  // register offsets
  localparam ufc_addr_t ADDR_CTL    = 4'h0;
  localparam ufc_addr_t ADDR_RX_LVL = 4'h1;
  localparam ufc_addr_t ADDR_TX_LVL = 4'h2;
  localparam ufc_addr_t ADDR_FL_HI  = 4'h3;
  localparam ufc_addr_t ADDR_FL_LO  = 4'h4;
  localparam ufc_addr_t ADDR_STAT   = 4'h5;
  localparam ufc_addr_t ADDR_MASK   = 4'h6;
  localparam ufc_addr_t ADDR_DATA   = 4'h7;
  localparam ufc_addr_t ADDR_RX_CNT = 4'h8;
  localparam ufc_addr_t ADDR_TX_CNT = 4'h9;

  // fifo control field positions
  localparam int unsigned CTL_EN    = 0;
  localparam int unsigned CTL_RXCLR = 1;
  localparam int unsigned CTL_TXCLR = 2;
  localparam int unsigned CTL_TXT   = 4;
  localparam int unsigned CTL_RXT   = 6;
  localparam ufc_byte_t   CTL_WMASK = 8'hf7;

  // reset values
  localparam ufc_byte_t CTL_RST = 8'h00;
  localparam ufc_byte_t LVL_RST = 8'h00;

  // coded trigger levels, bytes
  localparam ufc_byte_t RX_TRIG_0 = 8'h08;
  localparam ufc_byte_t RX_TRIG_1 = 8'h10;
  localparam ufc_byte_t RX_TRIG_2 = 8'h18;
  localparam ufc_byte_t RX_TRIG_3 = 8'h1c;
  localparam ufc_byte_t TX_TRIG_0 = 8'h10;
  localparam ufc_byte_t TX_TRIG_1 = 8'h08;
  localparam ufc_byte_t TX_TRIG_2 = 8'h18;
  localparam ufc_byte_t TX_TRIG_3 = 8'h1e;
  localparam ufc_byte_t LVL_MIN   = 8'h01;

  // fill limits with and without fifo mode
  localparam ufc_cnt_t FULL_DEPTH = 6'h20;
  localparam ufc_cnt_t HOLD_DEPTH = 6'h01;

  // interrupt status bits
  localparam int unsigned ST_RXREADY = 0;
  localparam int unsigned ST_TXEMP   = 1;
  localparam int unsigned ST_RXOVR   = 2;
  localparam int unsigned ST_W       = 3;
endpackage

// file: inc/ufc_fifo_if.sv
`timescale 1ns/1ps
// signals between the control logic and one byte store
interface ufc_fifo_if;
  import ufc_pkg::*;
  logic      push;   // write one byte
  logic      pop;    // drop the head byte
  logic      clr;    // empty the store
  ufc_byte_t din;    // byte to write
  ufc_cnt_t  limit;  // highest fill allowed
  ufc_byte_t dout;   // head byte, registered
  ufc_cnt_t  cnt;    // fill count
  logic      full;   // count at limit
  logic      empty;  // count zero
  modport owner (output push, pop, clr, din, limit,
                 input  dout, cnt, full, empty);
  modport store (input  push, pop, clr, din, limit,
                 output dout, cnt, full, empty);
endinterface

// file: hdl/ufc_fifo.sv
`timescale 1ns/1ps
// byte store with counter; head byte always waits in a register
module ufc_fifo
(
  // clock and reset
  input wire logic   clk_i,
  input wire logic   sys_rst_i,
  // control side
  ufc_fifo_if.store  f
);
  import ufc_pkg::*;

  ufc_byte_t        mem_q [DEPTH];  // storage, no reset needed
  logic [AW-1:0]    wr_q;           // write pointer
  logic [AW-1:0]    rd_q;           // read pointer
  logic [AW-1:0]    rd_nxt;         // read pointer after this edge
  ufc_cnt_t         cnt_q;          // fill count
  logic             do_push;        // accepted write
  logic             do_pop;         // accepted read

  // full against the live limit, so non-fifo mode holds one byte
  assign f.full  = cnt_q >= f.limit;
  assign f.empty = cnt_q == '0;
  assign f.cnt   = cnt_q;
  assign do_push = f.push && !f.full;
  assign do_pop  = f.pop && !f.empty;
  assign rd_nxt  = rd_q + AW'(do_pop);

  // storage write
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wr_q] <= f.din;
    end
  end

  // pointers and count; clear wins over traffic
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || f.clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_q + AW'(do_push);
      rd_q  <= rd_nxt;
      cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
    end
  end

  // head register; bypass when the new byte lands in the head slot
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || f.clr) begin
      f.dout <= '0;
    end else if (do_push && wr_q == rd_nxt) begin
      f.dout <= f.din;
    end else begin
      f.dout <= mem_q[rd_nxt];
    end
  end

  a_clear_empties: assert property (@(posedge clk_i)
    disable iff (sys_rst_i) f.clr |=> (cnt_q == '0) && f.empty)
    else $error("fifo not empty after clear");
endmodule

// file: hdl/ufc_top.sv
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// fifo control of a single uart: control register, levels, interrupts
module ufc_top
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // register port
  input  wire ufc_pkg::ufc_addr_t addr_i,
  input  wire ufc_pkg::ufc_byte_t wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output      ufc_pkg::ufc_byte_t rdata_o,
  // receiver side
  input  wire logic               rx_valid_i,
  input  wire ufc_pkg::ufc_byte_t rx_data_i,
  // transmitter side
  input  wire logic               tx_req_i,
  output      ufc_pkg::ufc_byte_t tx_data_o,
  output      logic               tx_strobe_o,
  output      logic               tx_pend_o,
  // status and flow
  output      logic               irq_o,
  output      logic               rx_ready_o,
  output      logic               rx_flow_stop_o,
  output      logic               tx_below_o,
  output      logic               fifo_en_o
);
  import ufc_pkg::*;

  ufc_fifo_if rxf ();               // receive store
  ufc_fifo_if txf ();               // transmit store

  ufc_byte_t        ctl_q;          // fifo_control_reg
  ufc_byte_t        rx_lvl_q;       // rx_interrupt_level_reg
  ufc_byte_t        tx_lvl_q;       // tx_interrupt_level_reg
  ufc_byte_t        fl_hi_q;        // flow_upper_threshold_reg
  ufc_byte_t        fl_lo_q;        // flow_lower_threshold_reg
  logic [ST_W-1:0]  status_q;       // interrupt_status_reg
  logic [ST_W-1:0]  mask_q;         // interrupt mask
  logic             tx_below_q;     // last cycle's below-level state
  logic             wr_ctl;         // control register write
  logic             rd_stat;        // status register read
  logic             fifo_en;        // fifo mode
  logic             override;       // level registers in charge
  ufc_byte_t        rx_code;        // coded receive level
  ufc_byte_t        tx_code;        // coded transmit level
  ufc_byte_t        rx_trig;        // effective receive level
  ufc_byte_t        tx_trig;        // effective transmit level
  logic             rx_at;          // receive count at level
  logic             tx_below;       // transmit count below level
  logic             tx_ev;          // transmit just fell below level
  logic [ST_W-1:0]  w1c;            // bits written with one

  // byte stores
  ufc_fifo u_rx_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .f         (rxf)
  );

  ufc_fifo u_tx_fifo (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .f         (txf)
  );

  // decode
  assign wr_ctl  = wr_i && (addr_i == ADDR_CTL);
  assign rd_stat = rd_i && (addr_i == ADDR_STAT);
  assign w1c     = (wr_i && addr_i == ADDR_STAT) ? wdata_i[ST_W-1:0] : '0;
  assign fifo_en = ctl_q[CTL_EN];

  // store hookup; a data read pops the receive head
  assign rxf.push  = rx_valid_i;
  assign rxf.din   = rx_data_i;
  assign rxf.pop   = rd_i && (addr_i == ADDR_DATA);
  assign rxf.clr   = ctl_q[CTL_RXCLR];
  assign txf.push  = wr_i && (addr_i == ADDR_DATA);
  assign txf.din   = wdata_i;
  assign txf.pop   = tx_req_i;
  assign txf.clr   = ctl_q[CTL_TXCLR];
  // without fifo mode each side is a one-byte holding register
  assign rxf.limit = fifo_en ? FULL_DEPTH : HOLD_DEPTH;
  assign txf.limit = fifo_en ? FULL_DEPTH : HOLD_DEPTH;

  // control register; bit 3 is dropped, clear bits live one cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctl_q <= CTL_RST;
    end else if (wr_ctl) begin
      ctl_q <= wdata_i & CTL_WMASK;
    end else begin
      // the store clears at this edge, so the bit can drop now
      ctl_q[CTL_RXCLR] <= 1'b0;
      ctl_q[CTL_TXCLR] <= 1'b0;
    end
  end

  // level and threshold registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_lvl_q <= LVL_RST;
      tx_lvl_q <= LVL_RST;
      fl_hi_q  <= LVL_RST;
      fl_lo_q  <= LVL_RST;
    end else if (wr_i) begin
      case (addr_i)
        ADDR_RX_LVL: rx_lvl_q <= wdata_i;
        ADDR_TX_LVL: tx_lvl_q <= wdata_i;
        ADDR_FL_HI:  fl_hi_q  <= wdata_i;
        ADDR_FL_LO:  fl_lo_q  <= wdata_i;
        default: ;
      endcase
    end
  end

  // coded levels from the control bits
  always_comb begin
    case (ctl_q[CTL_RXT +: 2])
      2'h0:    rx_code = RX_TRIG_0;
      2'h1:    rx_code = RX_TRIG_1;
      2'h2:    rx_code = RX_TRIG_2;
      default: rx_code = RX_TRIG_3;
    endcase
    case (ctl_q[CTL_TXT +: 2])
      2'h0:    tx_code = TX_TRIG_0;
      2'h1:    tx_code = TX_TRIG_1;
      2'h2:    tx_code = TX_TRIG_2;
      default: tx_code = TX_TRIG_3;
    endcase
  end

  // effective levels; a zero receive level would fire at once, a zero transmit level never, so floor at one
  assign override = |{rx_lvl_q, tx_lvl_q, fl_hi_q, fl_lo_q};
  always_comb begin
    if (!fifo_en) begin
      rx_trig = LVL_MIN;
      tx_trig = LVL_MIN;
    end else if (override) begin
      rx_trig = (rx_lvl_q == '0) ? LVL_MIN : rx_lvl_q;
      tx_trig = (tx_lvl_q == '0) ? LVL_MIN : tx_lvl_q;
    end else begin
      rx_trig = rx_code;
      tx_trig = tx_code;
    end
  end

  // level compares
  assign rx_at    = ufc_byte_t'(rxf.cnt) >= rx_trig;
  assign tx_below = ufc_byte_t'(txf.cnt) < tx_trig;
  assign tx_ev    = tx_below && !tx_below_q;

  // edge memory; starts below so reset itself is no event
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_below_q <= 1'b1;
    end else begin
      tx_below_q <= tx_below;
    end
  end

  // interrupt status; hardware set wins over any clear
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      status_q <= '0;
    end else begin
      // receive ready follows the level, cleared below it
      status_q[ST_RXREADY] <= rx_at;
      if (tx_ev) begin
        status_q[ST_TXEMP] <= 1'b1;
      end else if (w1c[ST_TXEMP] || rd_stat || txf.push) begin
        status_q[ST_TXEMP] <= 1'b0;
      end
      // overrun: a byte arrived with the receive store full
      if (rxf.push && rxf.full) begin
        status_q[ST_RXOVR] <= 1'b1;
      end else if (w1c[ST_RXOVR]) begin
        status_q[ST_RXOVR] <= 1'b0;
      end
    end
  end

  // interrupt mask
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= '0;
    end else if (wr_i && addr_i == ADDR_MASK) begin
      mask_q <= wdata_i[ST_W-1:0];
    end
  end

  // level outputs, one cycle behind the counts; irq_o one cycle behind the status register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_o          <= 1'b0;
      rx_ready_o     <= 1'b0;
      rx_flow_stop_o <= 1'b0;
      tx_below_o     <= 1'b1;
      fifo_en_o      <= 1'b0;
      tx_pend_o      <= 1'b0;
    end else begin
      irq_o          <= |(status_q & mask_q);
      rx_ready_o     <= rx_at;
      rx_flow_stop_o <= rx_at;
      tx_below_o     <= tx_below;
      fifo_en_o      <= fifo_en;
      tx_pend_o      <= !txf.empty;
    end
  end

  // transmit byte hand-off; a request to an empty store is dropped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_strobe_o <= 1'b0;
      tx_data_o   <= '0;
    end else begin
      tx_strobe_o <= tx_req_i && !txf.empty;
      if (tx_req_i && !txf.empty) begin
        tx_data_o <= txf.dout;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTL:    rdata_o <= ctl_q & CTL_WMASK;
        ADDR_RX_LVL: rdata_o <= rx_lvl_q;
        ADDR_TX_LVL: rdata_o <= tx_lvl_q;
        ADDR_FL_HI:  rdata_o <= fl_hi_q;
        ADDR_FL_LO:  rdata_o <= fl_lo_q;
        ADDR_STAT:   rdata_o <= ufc_byte_t'(status_q);
        ADDR_MASK:   rdata_o <= ufc_byte_t'(mask_q);
        ADDR_DATA:   rdata_o <= rxf.dout;
        ADDR_RX_CNT: rdata_o <= ufc_byte_t'(rxf.cnt);
        ADDR_TX_CNT: rdata_o <= ufc_byte_t'(txf.cnt);
        default:     rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // checks, all in the one clock domain
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_hold_one_byte: assert property (
    !fifo_en && rxf.cnt >= HOLD_DEPTH && rx_valid_i && !rxf.pop
    && !rxf.clr |=> rxf.cnt == $past(rxf.cnt))
    else $error("store grew past one byte without fifo mode");

  a_tx_clear_self: assert property (
    wr_ctl && wdata_i[CTL_TXCLR] |=> ctl_q[CTL_TXCLR]
    ##1 txf.empty && (!ctl_q[CTL_TXCLR] || $past(wr_ctl)))
    else $error("transmit clear did not empty or self-clear");

  a_rx_clear_self: assert property (
    wr_ctl && wdata_i[CTL_RXCLR] |=> ctl_q[CTL_RXCLR]
    ##1 rxf.empty && (!ctl_q[CTL_RXCLR] || $past(wr_ctl)))
    else $error("receive clear did not empty or self-clear");

  a_rx_code_top: assert property (
    fifo_en && !override && ctl_q[CTL_RXT +: 2] == 2'h3
    && ufc_byte_t'(rxf.cnt) == RX_TRIG_3 |=> rx_ready_o)
    else $error("receive ready missing at coded level");

  a_rx_ready_set: assert property (
    rx_at |=> rx_ready_o && rx_flow_stop_o && status_q[ST_RXREADY])
    else $error("receive ready or flow stop missing at level");

  a_tx_code_first: assert property (
    fifo_en && !override && ctl_q[CTL_TXT +: 2] == 2'h0
    && ufc_byte_t'(txf.cnt) == TX_TRIG_0 |=> !tx_below_o)
    else $error("transmit below-level wrong at coded level");

  a_tx_empty_evt: assert property (
    $rose(tx_below) |=> status_q[ST_TXEMP] && tx_below_o)
    else $error("transmit empty event not flagged");

  a_level_override: assert property (
    fifo_en && override && rx_lvl_q != '0
    && ufc_byte_t'(rxf.cnt) == rx_lvl_q |=> rx_ready_o)
    else $error("receive level register not obeyed");

  a_rx_withdraw: assert property (
    $fell(rx_at) |=> !rx_ready_o && !status_q[ST_RXREADY])
    else $error("receive ready kept below level");

  a_tx_int_clear: assert property (
    status_q[ST_TXEMP] && (rd_stat || txf.push) && !tx_ev
    |=> !status_q[ST_TXEMP])
    else $error("transmit empty not cleared by read or write");

  c_rx_cycle:  cover property (rx_ready_o ##[1:64] !rx_ready_o);
  c_tx_irq:    cover property (status_q[ST_TXEMP] && mask_q[ST_TXEMP]
                               ##1 irq_o);
  c_rx_flush:  cover property (wr_ctl && wdata_i[CTL_RXCLR]
                               && !rxf.empty);
  c_rx_full:   cover property (rxf.full && fifo_en);
endmodule

// file: dv/ufc_serial_model.sv
`timescale 1ns/1ps
// stand-in for the serial bit engine at the far side of the block
module ufc_serial_model
(
  // receiver side of the block
  input  wire logic               clk_i,
  output      logic               rx_valid_o,
  output      ufc_pkg::ufc_byte_t rx_data_o,
  // transmitter side of the block
  output      logic               tx_req_o,
  input  wire ufc_pkg::ufc_byte_t tx_data_i,
  input  wire logic               tx_strobe_i
);
  import ufc_pkg::*;
  // idle at time zero; an idle data line never shows a held byte
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h5a;
    tx_req_o   = 1'b0;
  end

  // hand over n bytes counting up from first, gap idle cycles apart
  task automatic send(input int n, input ufc_byte_t first, input int gap);
    ufc_byte_t b;
    b = first;
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o  <= b;
      for (int g = 0; g < gap; g++) begin
        @(posedge clk_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~b;
      end
      b = b + 8'h01;
    end
    // release: inverse of the last byte so a stale read cannot pass
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o  <= ~(b - 8'h01);
  endtask

  // ask for one byte; strobe and data stand in the cycle after the ask
  task automatic pull(output logic stb, output ufc_byte_t got);
    @(posedge clk_i);
    tx_req_o <= 1'b1;
    @(posedge clk_i);
    tx_req_o <= 1'b0;
    #1;
    stb = tx_strobe_i;
    got = tx_data_i;
  endtask
endmodule

// file: dv/uart_fifo_control_tb.sv
`timescale 1ns/1ps
// self-checking bench for the uart fifo control block
module uart_fifo_control_tb;
  import ufc_pkg::*;
  // clock, reset and register port
  logic      clk_i;
  logic      sys_rst_i;
  ufc_addr_t addr_i;
  ufc_byte_t wdata_i;
  logic      wr_i;
  logic      rd_i;
  ufc_byte_t rdata_o;
  // serial side, inputs driven by the model
  logic      rx_valid_i;
  ufc_byte_t rx_data_i;
  logic      tx_req_i;
  ufc_byte_t tx_data_o;
  logic      tx_strobe_o;
  logic      tx_pend_o;
  // status and flow
  logic      irq_o;
  logic      rx_ready_o;
  logic      rx_flow_stop_o;
  logic      tx_below_o;
  logic      fifo_en_o;
  // tallies
  int        n_mismatch;
  int        total_checks;
  // coded levels by field code
  ufc_byte_t rx_lvl [4] = '{RX_TRIG_0, RX_TRIG_1, RX_TRIG_2, RX_TRIG_3};
  ufc_byte_t tx_lvl [4] = '{TX_TRIG_0, TX_TRIG_1, TX_TRIG_2, TX_TRIG_3};

  ufc_top DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .tx_req_i(tx_req_i),
    .tx_data_o(tx_data_o), .tx_strobe_o(tx_strobe_o),
    .tx_pend_o(tx_pend_o), .irq_o(irq_o), .rx_ready_o(rx_ready_o),
    .rx_flow_stop_o(rx_flow_stop_o), .tx_below_o(tx_below_o),
    .fifo_en_o(fifo_en_o));

  ufc_serial_model sm (.clk_i(clk_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .tx_req_o(tx_req_i), .tx_data_i(tx_data_o),
    .tx_strobe_i(tx_strobe_o));

  // 200 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // compare a byte
  task automatic chk_byte(input string what, input ufc_byte_t exp,
                          input ufc_byte_t got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare a flag
  task automatic chk_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  // wait n edges, then let that edge's updates land
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input ufc_addr_t a, input ufc_byte_t d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask

  // one-cycle read strobe; data stand only in the following cycle
  task automatic reg_rd(input ufc_addr_t a, output ufc_byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // values straight after reset, unmapped read, enable and reserved bit
  task automatic t_enable();
    ufc_byte_t v;
    chk_bit("enable after reset", 1'b0, fifo_en_o);
    chk_bit("tx below after reset", 1'b1, tx_below_o);
    reg_rd(ADDR_CTL, v);
    chk_byte("control after reset", 8'h00, v);
    reg_rd(4'hf, v);
    chk_byte("unmapped read", 8'h00, v);
    reg_wr(ADDR_CTL, 8'h09); // reserved bit set deliberately
    cyc(2);
    chk_bit("enable set", 1'b1, fifo_en_o);
    reg_rd(ADDR_CTL, v);
    chk_byte("reserved bit ignored", 8'h01, v);
    reg_wr(ADDR_CTL, 8'h00);
    cyc(2);
    chk_bit("enable cleared", 1'b0, fifo_en_o);
  endtask

  // each receive code: clear, fill to one short, reach level, pop one
  task automatic t_rx_levels();
    ufc_byte_t v;
    for (int c = 0; c < 4; c++) begin
      reg_wr(ADDR_CTL, {c[1:0], 6'h03});
      reg_rd(ADDR_CTL, v);
      chk_byte("rx clear self-clears", {c[1:0], 6'h01}, v);
      reg_rd(ADDR_RX_CNT, v);
      chk_byte("rx count after clear", 8'h00, v);
      sm.send(int'(rx_lvl[c]) - 1, 8'h40, c % 2);
      cyc(3);
      chk_bit("rx ready one short", 1'b0, rx_ready_o);
      sm.send(1, 8'h80, 0);
      cyc(3);
      chk_bit("rx ready at level", 1'b1, rx_ready_o);
      chk_bit("rx flow stop", 1'b1, rx_flow_stop_o);
      reg_rd(ADDR_DATA, v);
      chk_byte("rx head after clear", 8'h40, v);
      cyc(3);
      chk_bit("rx ready withdrawn", 1'b0, rx_ready_o);
    end
  endtask

  // each transmit code: clear, fill to level, drain one, clear the event
  task automatic t_tx_levels();
    ufc_byte_t v;
    logic      s;
    reg_wr(ADDR_MASK, 8'h02);
    for (int c = 0; c < 4; c++) begin
      reg_wr(ADDR_CTL, {2'b00, c[1:0], 4'h5});
      reg_rd(ADDR_CTL, v);
      chk_byte("tx clear self-clears", {2'b00, c[1:0], 4'h1}, v);
      reg_rd(ADDR_TX_CNT, v);
      chk_byte("tx count after clear", 8'h00, v);
      for (int i = 0; i < int'(tx_lvl[c]); i++) begin
        reg_wr(ADDR_DATA, 8'h20 + i[7:0]);
      end
      reg_wr(ADDR_STAT, 8'h02);
      cyc(3);
      chk_bit("tx below at level", 1'b0, tx_below_o);
      chk_bit("irq quiet at level", 1'b0, irq_o);
      sm.pull(s, v);
      chk_bit("tx strobe", 1'b1, s);
      chk_byte("tx byte after clear", 8'h20, v);
      cyc(3);
      chk_bit("tx below one short", 1'b1, tx_below_o);
      chk_bit("irq at tx event", 1'b1, irq_o);
      if (c % 2 == 0) begin
        reg_rd(ADDR_STAT, v);
        chk_byte("status tx event", 8'h02, v & 8'h02);
      end else begin
        reg_wr(ADDR_DATA, 8'h77);
      end
      cyc(3);
      chk_bit("irq cleared", 1'b0, irq_o);
    end
  endtask

  // level registers override the coded levels, flow register alone too
  task automatic t_override();
    reg_wr(ADDR_CTL, 8'h07);
    reg_wr(ADDR_RX_LVL, 8'h03);
    reg_wr(ADDR_TX_LVL, 8'h05);
    sm.send(3, 8'h10, 1);
    cyc(3);
    chk_bit("rx ready override", 1'b1, rx_ready_o);
    for (int i = 0; i < 5; i++) begin
      reg_wr(ADDR_DATA, 8'h30);
    end
    cyc(3);
    chk_bit("tx below override", 1'b0, tx_below_o);
    reg_wr(ADDR_RX_LVL, 8'h00);
    reg_wr(ADDR_TX_LVL, 8'h00);
    reg_wr(ADDR_FL_HI, 8'h09);
    reg_wr(ADDR_CTL, 8'h03);
    sm.send(1, 8'h11, 0);
    cyc(3);
    chk_bit("rx ready via flow reg", 1'b1, rx_ready_o);
    reg_wr(ADDR_FL_HI, 8'h00);
    cyc(3);
    chk_bit("rx ready coded again", 1'b0, rx_ready_o);
  endtask

  // fifo off: each store holds one byte, a second one is refused
  task automatic t_hold();
    ufc_byte_t v;
    logic      s;
    reg_wr(ADDR_CTL, 8'h06);
    reg_wr(ADDR_MASK, 8'h04);
    sm.send(2, 8'h60, 0);
    cyc(3);
    chk_bit("rx ready holding", 1'b1, rx_ready_o);
    chk_bit("irq at overrun", 1'b1, irq_o);
    reg_rd(ADDR_RX_CNT, v);
    chk_byte("rx count without fifo", 8'h01, v);
    reg_rd(ADDR_DATA, v);
    chk_byte("rx held byte", 8'h60, v);
    reg_wr(ADDR_STAT, 8'h04);
    cyc(3);
    chk_bit("irq after overrun clear", 1'b0, irq_o);
    reg_wr(ADDR_DATA, 8'h31);
    reg_wr(ADDR_DATA, 8'h32);
    cyc(2);
    chk_bit("tx pending", 1'b1, tx_pend_o);
    reg_rd(ADDR_TX_CNT, v);
    chk_byte("tx count without fifo", 8'h01, v);
    sm.pull(s, v);
    chk_bit("tx strobe held byte", 1'b1, s);
    chk_byte("tx held byte", 8'h31, v);
    cyc(2);
    chk_bit("tx pending cleared", 1'b0, tx_pend_o);
  endtask

  // counts, verdict, end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    n_mismatch   = 0;
    total_checks = 0;
    sys_rst_i    = 1'b1;
    addr_i       = '0;
    wdata_i      = '0;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    cyc(1);
    t_enable();
    t_rx_levels();
    t_tx_levels();
    t_override();
    t_hold();
    tally_and_finish();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    tally_and_finish();
  end
endmodule
